// *** verilog/wavegen_pkg.sv ***
// Purpose: Shared constants for the setpoint waveform generator
// Assumes: 50 MHz mclk, APB register access
// Notes: Byte offsets of one aligned 32-bit word each
package wavegen_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_NS = 10_000;
  localparam int unsigned TICK_CYCLES = TICK_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned DATA_W = 16;
  localparam int unsigned TIME_W = 32;
  localparam logic [DATA_W-1:0] RATED_DEF = 16'hCCCC;
  localparam logic [DATA_W-1:0] RES_STEPS = 16'h0CCD;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_AMPL = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0C;
  localparam logic [7:0] OFS_PH1 = 8'h10;
  localparam logic [7:0] OFS_PH2 = 8'h14;
  localparam logic [7:0] OFS_PH3 = 8'h18;
  localparam logic [7:0] OFS_PH4 = 8'h1C;
  localparam logic [7:0] OFS_STATIC = 8'h20;
  localparam logic [7:0] OFS_LEVEL = 8'h24;
  localparam int unsigned CTRL_FUNC_LSB = 0;
  localparam int unsigned CTRL_CURR = 2;
  localparam int unsigned CTRL_LOAD = 3;
  localparam int unsigned CTRL_START = 4;
  localparam int unsigned CTRL_STOPK = 5;
  localparam int unsigned CTRL_TOGGLE = 6;
  localparam int unsigned CTRL_ENTER = 7;
  localparam int unsigned ST_INPUT_ON = 0;
  localparam int unsigned ST_RUN = 1;
  localparam int unsigned ST_READY = 2;
  localparam int unsigned ST_ALARM = 3;
  localparam int unsigned ST_REJECT = 4;
  localparam int unsigned ST_FGMODE = 5;
  localparam logic [1:0] FUNC_TRI = 2'h0;
  localparam logic [1:0] FUNC_RECT = 2'h1;
  localparam logic [1:0] FUNC_TRAP = 2'h2;
  localparam logic [1:0] FUNC_RAMP = 2'h3;
  typedef enum logic [2:0] {
    S_OFF, S_LOADED, S_RUN, S_HOLD
  } run_state_type;
endpackage

// *** verilog/setpoint_waveform_generator.sv ***
// Purpose: Function generator for the set value of an electronic load
// Assumes: APB slave, registers one aligned word each, zero wait states
// Notes: Writing CTRL command bits gives one-cycle command pulses
`timescale 1ns/1ps
`default_nettype none

module setpoint_waveform_generator #(
  parameter int unsigned TICK_DIV = wavegen_pkg::TICK_CYCLES
) (
  input wire logic mclk, // 50 MHz clock
  input wire logic arst_n, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic alarm, // Any device alarm level
  input wire logic fgModeEnter, // Pulse: generator mode entered
  output logic inputOn, // DC input switched on
  output logic applyCurrent, // Waveform targets current
  output logic [15:0] voltSet, // Voltage set value
  output logic [15:0] currSet, // Current set value
  output logic [15:0] powerSet, // Power limit
  output logic alarmFlag // Alarm reported
);
  localparam int unsigned DW = wavegen_pkg::DATA_W;
  localparam int unsigned TW = wavegen_pkg::TIME_W;

  typedef struct packed {
    wavegen_pkg::run_state_type st;
    logic [1:0] func;
    logic cur;
    logic [DW-1:0] ampl;
    logic [DW-1:0] ofs;
    logic [DW-1:0] stat;
    logic [3:0][TW-1:0] ph;
    logic [1:0] phase;
    logic [TW-1:0] cnt;
    logic [15:0] div;
    logic [DW-1:0] level;
    logic on;
    logic alm;
    logic reject;
    logic fg;
    logic [DW-1:0] vLim;
    logic [DW-1:0] iLim;
    logic [DW-1:0] pLim;
    logic [31:0] rd;
  } state_type;

  state_type s_reg, s_next;

  wire logic wrEn = psel && penable && pwrite;
  wire logic rdEn = psel && !penable && !pwrite;
  wire logic running = (s_reg.st == wavegen_pkg::S_RUN);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= wavegen_pkg::OFS_LEVEL);
  endfunction

  // Linear interpolation between lo and hi by cnt/len, quantised
  function automatic logic [DW-1:0] interp(input logic [DW-1:0] lo,
      input logic [DW-1:0] hi, input logic [TW-1:0] c,
      input logic [TW-1:0] len);
    logic [DW+TW-1:0] prod;
    logic [DW-1:0] d;
    logic [DW-1:0] q;
    prod = '0;
    d = '0;
    q = '0;
    if (len == '0) begin
      interp = hi;
    end else if (hi >= lo) begin
      d = hi - lo;
      prod = (DW+TW)'(d) * (DW+TW)'(c);
      q = DW'(prod / (DW+TW)'(len));
      q = q - (q % wavegen_pkg::RES_STEPS);
      interp = lo + q;
    end else begin
      d = lo - hi;
      prod = (DW+TW)'(d) * (DW+TW)'(c);
      q = DW'(prod / (DW+TW)'(len));
      q = q - (q % wavegen_pkg::RES_STEPS);
      interp = lo - q;
    end
  endfunction

  logic [DW-1:0] top;
  logic [DW:0] sum;
  logic tick;
  logic [1:0] nextPh;
  logic endPh;
  logic doLoad, doStart, doStopK, doToggle;

  always_comb begin
    s_next = s_reg;
    sum = (DW+1)'(s_reg.ampl) + (DW+1)'(s_reg.ofs);
    top = s_reg.ofs + s_reg.ampl;
    tick = (s_reg.div == 16'(TICK_DIV - 1));
    nextPh = s_reg.phase + 2'h1;
    endPh = 1'b0;
    doLoad = wrEn && paddr == wavegen_pkg::OFS_CTRL &&
      pwdata[wavegen_pkg::CTRL_LOAD];
    doStart = wrEn && paddr == wavegen_pkg::OFS_CTRL &&
      pwdata[wavegen_pkg::CTRL_START];
    doStopK = wrEn && paddr == wavegen_pkg::OFS_CTRL &&
      pwdata[wavegen_pkg::CTRL_ENTER];
    doToggle = wrEn && paddr == wavegen_pkg::OFS_CTRL &&
      pwdata[wavegen_pkg::CTRL_TOGGLE];
    s_next.reject = s_reg.reject;
    if (fgModeEnter) begin
      s_next.fg = 1'b1;
      s_next.vLim = wavegen_pkg::RATED_DEF;
      s_next.iLim = '0;
      s_next.pLim = '0;
    end
    // Parameter writes only with the input off
    if (wrEn && paddr != wavegen_pkg::OFS_CTRL &&
        paddr != wavegen_pkg::OFS_STATUS) begin
      if (s_reg.on) begin
        s_next.reject = 1'b1;
      end else begin
        case (paddr)
          wavegen_pkg::OFS_AMPL: s_next.ampl = pwdata[DW-1:0];
          wavegen_pkg::OFS_OFFSET: s_next.ofs = pwdata[DW-1:0];
          wavegen_pkg::OFS_PH1: s_next.ph[0] = pwdata;
          wavegen_pkg::OFS_PH2: s_next.ph[1] = pwdata;
          wavegen_pkg::OFS_PH3: s_next.ph[2] = pwdata;
          wavegen_pkg::OFS_PH4: s_next.ph[3] = pwdata;
          wavegen_pkg::OFS_STATIC: s_next.stat = pwdata[DW-1:0];
          default: s_next.stat = s_reg.stat;
        endcase
      end
    end
    if (wrEn && paddr == wavegen_pkg::OFS_CTRL) begin
      if (!s_reg.on) begin
        s_next.func = pwdata[wavegen_pkg::CTRL_FUNC_LSB +: 2];
        s_next.cur = pwdata[wavegen_pkg::CTRL_CURR];
      end else if (pwdata[1:0] != s_reg.func ||
          pwdata[wavegen_pkg::CTRL_CURR] != s_reg.cur) begin
        s_next.reject = 1'b1;
      end
    end
    if (wrEn && paddr == wavegen_pkg::OFS_STATUS &&
        pwdata[wavegen_pkg::ST_REJECT]) begin
      s_next.reject = 1'b0;
    end
    // Clamp amplitude and offset to the rating
    // Ramp levels are not clamped, neither each level nor their sum
    if (s_reg.func != wavegen_pkg::FUNC_RAMP &&
        sum > (DW+1)'(wavegen_pkg::RATED_DEF)) begin
      if (s_reg.ofs > wavegen_pkg::RATED_DEF) begin
        s_next.ofs = wavegen_pkg::RATED_DEF;
        s_next.ampl = '0;
      end else begin
        s_next.ampl = wavegen_pkg::RATED_DEF - s_reg.ofs;
      end
    end
    s_next.div = (tick || !running) ? 16'h0000 : s_reg.div + 16'h0001;
    case (s_reg.st)
      wavegen_pkg::S_OFF: begin
        s_next.phase = 2'h0;
        s_next.cnt = '0;
        s_next.level = s_next.cur ? '0 : s_reg.stat;
        if (doLoad) begin
          s_next.on = 1'b1;
          s_next.st = wavegen_pkg::S_LOADED;
        end
      end
      wavegen_pkg::S_LOADED, wavegen_pkg::S_HOLD: begin
        if (s_reg.st == wavegen_pkg::S_LOADED) begin
          s_next.level = s_next.cur ? '0 : s_reg.stat;
        end
        if (doStart || (doToggle && !s_reg.on)) begin
          s_next.on = 1'b1;
          s_next.st = wavegen_pkg::S_RUN;
          s_next.phase = 2'h0;
          s_next.cnt = '0;
          s_next.level = (s_reg.func == wavegen_pkg::FUNC_RAMP) ?
            s_reg.ampl : s_reg.ofs;
        end else if (doToggle) begin
          s_next.on = 1'b0;
        end else if (doLoad) begin
          s_next.on = 1'b1;
          s_next.st = wavegen_pkg::S_LOADED;
        end
      end
      wavegen_pkg::S_RUN: begin
        if (tick) begin
          s_next.cnt = s_reg.cnt + TW'(1);
          endPh = (s_reg.cnt + TW'(1) >= s_reg.ph[s_reg.phase]);
        end
        if (s_reg.ph[s_reg.phase] == '0) begin
          endPh = 1'b1;
        end
        case (s_reg.func)
          wavegen_pkg::FUNC_TRI: begin
            s_next.level = (s_reg.phase == 2'h0) ?
              interp(s_reg.ofs, top, s_reg.cnt, s_reg.ph[0]) :
              interp(top, s_reg.ofs, s_reg.cnt, s_reg.ph[1]);
            if (endPh) begin
              s_next.level = (s_reg.phase == 2'h0) ? top : s_reg.ofs;
              s_next.phase = (s_reg.phase == 2'h0) ? 2'h1 : 2'h0;
              s_next.cnt = '0;
            end
          end
          wavegen_pkg::FUNC_RECT: begin
            s_next.level = (s_reg.phase == 2'h0) ? top : s_reg.ofs;
            if (endPh) begin
              s_next.phase = (s_reg.phase == 2'h0) ? 2'h1 : 2'h0;
              s_next.cnt = '0;
            end
          end
          wavegen_pkg::FUNC_TRAP: begin
            case (s_reg.phase)
              2'h0: s_next.level =
                interp(s_reg.ofs, top, s_reg.cnt, s_reg.ph[0]);
              2'h1: s_next.level = top;
              2'h2: s_next.level =
                interp(top, s_reg.ofs, s_reg.cnt, s_reg.ph[2]);
              default: s_next.level = s_reg.ofs;
            endcase
            if (endPh) begin
              // Slope ends exactly on its target level
              s_next.level = (s_reg.phase[1] == 1'b0) ? top : s_reg.ofs;
              s_next.phase = nextPh;
              s_next.cnt = '0;
            end
          end
          default: begin
            // Ramp: ampl holds start, offset holds end
            s_next.level = interp(s_reg.ampl, s_reg.ofs, s_reg.cnt,
              s_reg.ph[0]);
            if (endPh) begin
              s_next.level = s_reg.ofs;
              s_next.st = wavegen_pkg::S_HOLD;
            end
          end
        endcase
        if (doStopK) begin
          s_next.st = wavegen_pkg::S_LOADED;
          s_next.level = s_reg.cur ? '0 : s_reg.stat;
        end
        if (doToggle) begin
          // Function stays loaded; toggle may restart it
          s_next.st = wavegen_pkg::S_LOADED;
          s_next.on = 1'b0;
          s_next.level = s_reg.cur ? '0 : s_reg.stat;
        end
      end
      default: s_next.st = wavegen_pkg::S_OFF;
    endcase
    if (alarm) begin
      s_next.st = wavegen_pkg::S_OFF;
      s_next.on = 1'b0;
      s_next.alm = 1'b1;
    end else if (wrEn && paddr == wavegen_pkg::OFS_STATUS &&
        pwdata[wavegen_pkg::ST_ALARM]) begin
      s_next.alm = 1'b0;
    end
    s_next.rd = '0;
    if (rdEn) begin
      case (paddr)
        wavegen_pkg::OFS_CTRL: s_next.rd = {29'h0000_0000, s_reg.cur,
          s_reg.func};
        wavegen_pkg::OFS_STATUS: s_next.rd = {26'h000_0000, s_reg.fg,
          s_reg.reject, s_reg.alm, s_reg.st == wavegen_pkg::S_LOADED,
          running, s_reg.on};
        wavegen_pkg::OFS_AMPL: s_next.rd = {16'h0000, s_reg.ampl};
        wavegen_pkg::OFS_OFFSET: s_next.rd = {16'h0000, s_reg.ofs};
        wavegen_pkg::OFS_PH1: s_next.rd = s_reg.ph[0];
        wavegen_pkg::OFS_PH2: s_next.rd = s_reg.ph[1];
        wavegen_pkg::OFS_PH3: s_next.rd = s_reg.ph[2];
        wavegen_pkg::OFS_PH4: s_next.rd = s_reg.ph[3];
        wavegen_pkg::OFS_STATIC: s_next.rd = {16'h0000, s_reg.stat};
        wavegen_pkg::OFS_LEVEL: s_next.rd = {16'h0000, s_reg.level};
        default: s_next.rd = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Zero wait state slave; read data registered in the setup cycle
  always_comb begin
    pready = 1'b1;
    pslverr = psel && penable && !mapped(paddr);
    prdata = s_reg.rd;
  end

  // Only the selected quantity follows the waveform
  always_comb begin
    inputOn = s_reg.on;
    applyCurrent = s_reg.cur;
    voltSet = s_reg.cur ? s_reg.vLim : s_reg.level;
    currSet = s_reg.cur ? s_reg.level : s_reg.iLim;
    powerSet = s_reg.pLim;
    alarmFlag = s_reg.alm;
  end

  alarm_off_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    alarm |=> !inputOn && alarmFlag)
    else $error("Alarm did not switch input off");
  toggle_stop_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (running && wrEn && paddr == 8'h00 && pwdata[6] && !alarm)
    |=> !inputOn)
    else $error("Toggle stop left input on");
  enter_stop_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (running && wrEn && paddr == 8'h00 && pwdata[7] && !pwdata[6] &&
    !alarm) |=> inputOn && !running)
    else $error("Enter stop wrong");
  load_on_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (s_reg.st == wavegen_pkg::S_OFF && wrEn && paddr == 8'h00 &&
    pwdata[3] && !alarm) |=> inputOn)
    else $error("Load did not switch input on");
  clamp_sum_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (s_reg.func != wavegen_pkg::FUNC_RAMP && sum > 17'h0_CCCC && !wrEn)
    |=> (17'(s_reg.ampl) + 17'(s_reg.ofs) <= 17'h0_CCCC))
    else $error("Amplitude plus offset over range");
  mode_limits_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    fgModeEnter |=> s_reg.vLim == wavegen_pkg::RATED_DEF &&
    powerSet == 16'h0000)
    else $error("Limits not reset on mode entry");
  run_on_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    running |-> inputOn)
    else $error("Running with input off");
  param_lock_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (inputOn && wrEn && paddr == wavegen_pkg::OFS_AMPL)
    |=> $stable(s_reg.ampl))
    else $error("Parameter changed with input on");
  curr_zero_a: assert property (
    @(posedge mclk) disable iff (!arst_n)
    ((s_reg.st == wavegen_pkg::S_OFF || s_reg.st == wavegen_pkg::S_LOADED)
    && applyCurrent) |-> currSet == 16'h0000)
    else $error("Current not starting from zero");
endmodule // setpoint_waveform_generator

`default_nettype wire

// *** test/regulation_stage.sv ***
// Purpose: Behavioural regulation stage and alarm source of the load
// Assumes: Trip request comes from the bench
// Notes: Alarm level follows a registered trip request
`timescale 1ns/1ps
`default_nettype none
module regulation_stage (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic inputOn, // DC input on
  input wire logic applyCurrent, // Waveform on current
  input wire logic [15:0] voltSet, // Voltage set value
  input wire logic [15:0] currSet, // Current set value
  input wire logic trip, // Bench request for a fault
  output logic alarm, // Device alarm level
  output logic [15:0] level // Regulated level
);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alarm <= 1'b0;
    end else begin
      alarm <= trip;
    end
  end
  // Input off regulates nothing
  assign level = !inputOn ? 16'h0000 : applyCurrent ? currSet : voltSet;
endmodule // regulation_stage
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Self-checking bench of the setpoint waveform generator
// Assumes: Zero wait state APB, TICK_DIV of 4 cycles
// Notes: Scenarios run in sequence on one instance
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned TDIV = 4;
  logic mclk = 1'b0;
  logic arstN = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alarm;
  logic trip = 1'b0;
  logic fgModeEnter = 1'b0;
  logic inputOn;
  logic applyCurrent;
  logic [15:0] voltSet;
  logic [15:0] currSet;
  logic [15:0] powerSet;
  logic alarmFlag;
  logic [15:0] level;
  logic [31:0] ctrlBase;
  logic [31:0] rdv;
  logic err;
  int failCount = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #10 mclk = ~mclk;
  setpoint_waveform_generator #(.TICK_DIV(TDIV)) setpoint_waveform_generator_i (
    .mclk(mclk), .arst_n(arstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm(alarm),
    .fgModeEnter(fgModeEnter), .inputOn(inputOn),
    .applyCurrent(applyCurrent), .voltSet(voltSet), .currSet(currSet),
    .powerSet(powerSet), .alarmFlag(alarmFlag));
  regulation_stage regulation_stage_i (
    .mclk(mclk), .arst_n(arstN), .inputOn(inputOn),
    .applyCurrent(applyCurrent), .voltSet(voltSet), .currSet(currSet),
    .trip(trip), .alarm(alarm), .level(level));
  task automatic tallyAndFinish;
    if (failCount == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      failCount++;
      tallyAndFinish();
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input int b);
    apb(1'b1, wavegen_pkg::OFS_CTRL, ctrlBase | (32'h1 << b));
    repeat (4) @(negedge mclk);
  endtask
  task automatic stat(input string what, input int b, input logic e);
    apb(1'b0, wavegen_pkg::OFS_STATUS, 32'h0);
    check(what, rdv[b], e);
  endtask
  task automatic waitlvl(input logic c, input logic [15:0] v);
    int k;
    k = 0;
    while ((c ? currSet : voltSet) !== v && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    check("level reached", c ? currSet : voltSet, v);
  endtask
  task automatic setup(input logic [1:0] f, input logic c,
      input logic [15:0] am, input logic [15:0] ofs, input logic [15:0] st,
      input logic [31:0] p1, input logic [31:0] p2);
    ctrlBase = {29'h0, c, f};
    apb(1'b1, wavegen_pkg::OFS_AMPL, {16'h0000, am});
    apb(1'b1, wavegen_pkg::OFS_OFFSET, {16'h0000, ofs});
    apb(1'b1, wavegen_pkg::OFS_PH1, p1);
    apb(1'b1, wavegen_pkg::OFS_PH2, p2);
    apb(1'b1, wavegen_pkg::OFS_PH3, p1);
    apb(1'b1, wavegen_pkg::OFS_PH4, p2);
    apb(1'b1, wavegen_pkg::OFS_STATIC, {16'h0000, st});
    cmd(wavegen_pkg::CTRL_LOAD);
    check("input on", inputOn, 1'b1);
    stat("ready", wavegen_pkg::ST_READY, 1'b1);
  endtask
  task automatic modeEntry;
    @(posedge mclk);
    fgModeEnter <= 1'b1;
    @(posedge mclk);
    fgModeEnter <= 1'b0;
    repeat (2) @(negedge mclk);
    check("volt static", voltSet, 16'h0000);
    check("curr limit", currSet, 16'h0000);
    check("power limit", powerSet, 16'h0000);
    stat("fg mode", wavegen_pkg::ST_FGMODE, 1'b1);
  endtask
  task automatic rectRun;
    setup(wavegen_pkg::FUNC_RECT, 1'b0, 16'h199A, 16'h1000, 16'h0800, 3, 2);
    check("static before", voltSet, 16'h0800);
    check("regulated", level, 16'h0800);
    cmd(wavegen_pkg::CTRL_START);
    stat("running", wavegen_pkg::ST_RUN, 1'b1);
    waitlvl(1'b0, 16'h1000);
    waitlvl(1'b0, 16'h299A);
    for (n = 0; voltSet === 16'h299A && n < 200; n++) @(negedge mclk);
    check("pulse length", n >= 3 * TDIV - 1 && n <= 3 * TDIV + 1, 1);
    for (n = 0; voltSet === 16'h1000 && n < 200; n++) @(negedge mclk);
    check("pause length", n >= 2 * TDIV - 1 && n <= 2 * TDIV + 1, 1);
    apb(1'b1, wavegen_pkg::OFS_AMPL, 32'h0000_0100);
    stat("reject", wavegen_pkg::ST_REJECT, 1'b1);
    apb(1'b0, wavegen_pkg::OFS_AMPL, 32'h0);
    check("ampl kept", rdv, 32'h0000_199A);
    apb(1'b1, wavegen_pkg::OFS_STATUS, 32'h0000_0010);
    cmd(wavegen_pkg::CTRL_ENTER);
    check("on after enter", inputOn, 1'b1);
    check("static after", voltSet, 16'h0800);
    stat("halted", wavegen_pkg::ST_RUN, 1'b0);
    cmd(wavegen_pkg::CTRL_START);
    cmd(wavegen_pkg::CTRL_TOGGLE);
    check("off by toggle", inputOn, 1'b0);
    stat("halted", wavegen_pkg::ST_RUN, 1'b0);
    cmd(wavegen_pkg::CTRL_TOGGLE);
    check("on by toggle", inputOn, 1'b1);
    stat("started", wavegen_pkg::ST_RUN, 1'b1);
  endtask
  task automatic alarmRun;
    @(posedge mclk);
    trip <= 1'b1;
    repeat (4) @(negedge mclk);
    check("off by alarm", inputOn, 1'b0);
    check("alarm flag", alarmFlag, 1'b1);
    stat("aborted", wavegen_pkg::ST_RUN, 1'b0);
    @(posedge mclk);
    trip <= 1'b0;
    apb(1'b1, wavegen_pkg::OFS_STATUS, 32'h0000_0008);
    stat("alarm clear", wavegen_pkg::ST_ALARM, 1'b0);
    apb(1'b1, wavegen_pkg::OFS_OFFSET, 32'h0000_1000);
    apb(1'b1, wavegen_pkg::OFS_AMPL, 32'h0000_C000);
    apb(1'b0, wavegen_pkg::OFS_AMPL, 32'h0);
    check("ampl clamped", rdv, 32'h0000_BCCC);
  endtask
  task automatic slopeRun(input logic [1:0] f);
    setup(f, 1'b0, 16'h199A, 16'h0000, 16'h0000, 5, 0);
    cmd(wavegen_pkg::CTRL_START);
    waitlvl(1'b0, 16'h199A);
    waitlvl(1'b0, 16'h0000);
    cmd(wavegen_pkg::CTRL_TOGGLE);
  endtask
  task automatic rampRun;
    // Static equals the ramp start level
    setup(wavegen_pkg::FUNC_RAMP, 1'b1, 16'h0000, 16'h199A, 16'h0000, 5, 0);
    check("current from zero", currSet, 16'h0000);
    check("on current", applyCurrent, 1'b1);
    check("volt limit", voltSet, 16'hCCCC);
    cmd(wavegen_pkg::CTRL_START);
    waitlvl(1'b1, 16'h199A);
    repeat (40) @(negedge mclk);
    check("end held", currSet, 16'h199A);
    stat("ran once", wavegen_pkg::ST_RUN, 1'b0);
    apb(1'b0, 8'h28, 32'h0);
    check("unmapped", err, 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    arstN <= 1'b1;
    modeEntry();
    rectRun();
    alarmRun();
    slopeRun(wavegen_pkg::FUNC_TRI);
    slopeRun(wavegen_pkg::FUNC_TRAP);
    rampRun();
    tallyAndFinish();
  end
endmodule // testbench
`default_nettype wire
